// file: atp_pkg.sv
// Purpose: Shared constants for acquisition trigger and pacing logic
// Assumes: 250 MHz core clock, APB register access
// Notes:   Threshold codes are offset binary over the trigger range
package atp_pkg;

  // Core clock
  localparam int CLK_MHZ          = 250;
  // External pacing ceiling, and least pacing period in clock cycles
  localparam int EXT_PACE_MAX_KHZ = 250;
  localparam int PACE_MIN_CYC     =
    (CLK_MHZ * 1000 + EXT_PACE_MAX_KHZ - 1) / EXT_PACE_MAX_KHZ;

  // Threshold code: 12 bits over -10 V .. +10 V, 4.88 mV a step
  localparam int THR_BITS         = 12;
  localparam int THR_STEP_UV      = 4880;
  localparam int THR_SPAN_MV      = 20000;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_THR_HIGH = 8'h08;
  localparam logic [7:0] ADDR_THR_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_PACE_DIV = 8'h10;
  localparam logic [7:0] ADDR_SAMPLES  = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_DONE_CNT = 8'h1c;

  // Control field positions
  localparam int CTRL_W        = 5;
  localparam int CTRL_TRIG_EN  = 0;
  localparam int CTRL_EXT_PACE = 1;
  localparam int CTRL_BELOW    = 2;
  localparam int CTRL_EDGE     = 3;
  localparam int CTRL_RETRIG   = 4;

  // Command bits, write one to act
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;

  // Status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_OVERRATE  = 2;
  localparam int ST_TRIGGERED = 3;

  // Reset values
  localparam logic [4:0]  CTRL_RESET     = 5'h00;
  localparam logic [11:0] THR_HIGH_RESET = 12'h800;
  localparam logic [11:0] THR_LOW_RESET  = 12'h800;
  localparam logic [31:0] PACE_DIV_RESET = 32'h000003e8;
  localparam logic [31:0] SAMPLES_RESET  = 32'h00000000;

  typedef enum logic [1:0] {
    ATP_IDLE,
    ATP_ARMED,
    ATP_ACQ
  } atp_state_t;

endpackage : atp_pkg

// file: atp_pace_gen.sv
// Purpose: Conversion pacing from internal divider or external input
// Assumes: extPaceIn is synchronous to clock
// Notes:   Divider below the pacing ceiling is clamped up to it
`timescale 1ns/10ps
module atp_pace_gen #(
  parameter int MIN_CYC = atp_pkg::PACE_MIN_CYC
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        useExt,
  input  wire logic [31:0] divisor,
  input  wire logic        extPaceIn,
  output logic             tick,
  output logic             paceOut,
  output logic             overrate
);

  logic [31:0] cnt_reg, cnt_next;
  logic [15:0] gap_reg, gap_next;
  logic        extPrev_reg, extPrev_next;
  logic        tick_reg, tick_next;
  logic        paceOut_reg, paceOut_next;
  logic        over_reg, over_next;
  logic [31:0] divEff;
  logic        extRise;

  always_comb begin
    divEff = (divisor < 32'(MIN_CYC)) ? 32'(MIN_CYC) : divisor;
    extRise = extPaceIn & ~extPrev_reg;
    extPrev_next = extPaceIn;
    gap_next = (gap_reg == 16'hffff) ? gap_reg : gap_reg + 16'h0001;
    cnt_next = 32'h00000000;
    tick_next = 1'b0;
    paceOut_next = 1'b0;
    over_next = 1'b0;
    if (run && useExt) begin
      tick_next = extRise;
      paceOut_next = extPaceIn;
      if (extRise) begin
        gap_next = 16'h0000;
        // Edges closer than the ceiling still pace, but are flagged
        over_next = gap_reg < 16'(MIN_CYC - 1);
      end
    end else if (run) begin
      tick_next = (cnt_reg == 32'h00000000);
      cnt_next = (cnt_reg >= divEff - 32'h00000001) ? 32'h00000000
                                                     : cnt_reg + 32'h00000001;
      paceOut_next = cnt_reg < (divEff >> 1);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg     <= 32'h00000000;
      gap_reg     <= 16'hffff;
      extPrev_reg <= 1'b0;
      tick_reg    <= 1'b0;
      paceOut_reg <= 1'b0;
      over_reg    <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      gap_reg     <= gap_next;
      extPrev_reg <= extPrev_next;
      tick_reg    <= tick_next;
      paceOut_reg <= paceOut_next;
      over_reg    <= over_next;
    end
  end

  assign tick     = tick_reg;
  assign paceOut  = paceOut_reg;
  assign overrate = over_reg;

endmodule : atp_pace_gen

// file: atp_trigger_pacing.sv
// Purpose: Trigger arming and conversion pacing with an APB register file
// Assumes: trigger_input is a 12-bit offset-binary code, synchronous
// Notes:   Zero-wait APB; read data is captured in the setup cycle
//
// What this block does
// - External pacing input times conversions, 250 kHz
// - Pacing clock output follows clock in use
// - 12-bit threshold codes span trigger range
// - Above level: start while input over high
// - Below level: start while input under low
// - Above edge: start on first upward crossing
// - Below edge: start on first downward crossing
// - Retrigger re-arms after requested sample count
// - Scan starts by command or trigger, stops on sample count or host stop
// - Each paced conversion gives one convStrobe pulse
`timescale 1ns/10ps
module atp_trigger_pacing #(
  parameter int MIN_CYC = atp_pkg::PACE_MIN_CYC
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] trigger_input,
  input  wire logic        extPaceIn,
  output logic             paceClockOut,
  output logic             convStrobe,
  output logic             scanActive,
  output logic             acquiring
);

  // Register file state
  logic [4:0]  ctrl_reg, ctrl_next;
  logic [11:0] thrHigh_reg, thrHigh_next;
  logic [11:0] thrLow_reg, thrLow_next;
  logic [31:0] paceDiv_reg, paceDiv_next;
  logic [31:0] samples_reg, samples_next;
  logic        over_reg, over_next;
  logic        trigd_reg, trigd_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  // Scan state
  atp_pkg::atp_state_t state_reg, state_next;
  logic [31:0] doneCnt_reg, doneCnt_next;
  logic        prevCond_reg, prevCond_next;
  logic        prevValid_reg, prevValid_next;
  logic        conv_reg, conv_next;
  logic        active_reg, active_next;
  logic        acq_reg, acq_next;

  logic        wrDone;
  logic        mapped;
  logic        cmdStart;
  logic        cmdStop;
  logic        isAbove;
  logic        isBelow;
  logic        cond;
  logic        fire;
  logic        tick;
  logic        overPulse;
  logic        paceRun;
  logic        lastSample;

  // APB slave
  always_comb begin
    wrDone = psel & penable & pready_reg & pwrite;
    mapped = (paddr == atp_pkg::ADDR_CTRL)     ||
             (paddr == atp_pkg::ADDR_CMD)      ||
             (paddr == atp_pkg::ADDR_THR_HIGH) ||
             (paddr == atp_pkg::ADDR_THR_LOW)  ||
             (paddr == atp_pkg::ADDR_PACE_DIV) ||
             (paddr == atp_pkg::ADDR_SAMPLES)  ||
             (paddr == atp_pkg::ADDR_STATUS)   ||
             (paddr == atp_pkg::ADDR_DONE_CNT);
    pready_next = psel & ~penable;
    // Unmapped offsets answer with an error
    pslverr_next = psel & ~penable & ~mapped;
    prdata_next = 32'h00000000;
    // Read data taken in setup, so status may lag a cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        atp_pkg::ADDR_CTRL:     prdata_next = {27'h0000000, ctrl_reg};
        atp_pkg::ADDR_THR_HIGH: prdata_next = {20'h00000, thrHigh_reg};
        atp_pkg::ADDR_THR_LOW:  prdata_next = {20'h00000, thrLow_reg};
        atp_pkg::ADDR_PACE_DIV: prdata_next = paceDiv_reg;
        atp_pkg::ADDR_SAMPLES:  prdata_next = samples_reg;
        atp_pkg::ADDR_DONE_CNT: prdata_next = doneCnt_reg;
        atp_pkg::ADDR_STATUS: begin
          prdata_next[atp_pkg::ST_STATE_LSB +: 2] = state_reg;
          prdata_next[atp_pkg::ST_OVERRATE]       = over_reg;
          prdata_next[atp_pkg::ST_TRIGGERED]      = trigd_reg;
        end
        default:                prdata_next = 32'h00000000;
      endcase
    end
  end

  // Configuration writes
  always_comb begin
    ctrl_next    = ctrl_reg;
    thrHigh_next = thrHigh_reg;
    thrLow_next  = thrLow_reg;
    paceDiv_next = paceDiv_reg;
    samples_next = samples_reg;
    cmdStart     = 1'b0;
    cmdStop      = 1'b0;
    if (wrDone) begin
      case (paddr)
        atp_pkg::ADDR_CTRL:     ctrl_next = pwdata[4:0];
        atp_pkg::ADDR_THR_HIGH: thrHigh_next = pwdata[11:0];
        atp_pkg::ADDR_THR_LOW:  thrLow_next = pwdata[11:0];
        atp_pkg::ADDR_PACE_DIV: paceDiv_next = pwdata;
        atp_pkg::ADDR_SAMPLES:  samples_next = pwdata;
        // Command bits act once and are never stored
        atp_pkg::ADDR_CMD: begin
          cmdStart = pwdata[atp_pkg::CMD_START];
          cmdStop  = pwdata[atp_pkg::CMD_STOP];
        end
        default: begin
          // Read-only offsets take the write and drop it
        end
      endcase
    end
    // Sticky pacing fault: write one to clear, a new fault wins
    over_next = over_reg;
    if (wrDone && paddr == atp_pkg::ADDR_STATUS &&
        pwdata[atp_pkg::ST_OVERRATE]) begin
      over_next = 1'b0;
    end
    if (overPulse) begin
      over_next = 1'b1;
    end
  end

  // Threshold comparison and trigger qualification
  always_comb begin
    // Strict compares: a code equal to a threshold is not past it
    isAbove = trigger_input > thrHigh_reg;
    isBelow = trigger_input < thrLow_reg;
    cond = ctrl_reg[atp_pkg::CTRL_BELOW] ? isBelow : isAbove;
    if (!ctrl_reg[atp_pkg::CTRL_EDGE]) begin
      // Level mode fires at once if already past the threshold
      fire = cond;
    end else begin
      // Edge needs one sample not past the threshold after arming
      fire = cond & prevValid_reg & ~prevCond_reg;
    end
  end

  // Scan control
  always_comb begin
    state_next     = state_reg;
    doneCnt_next   = doneCnt_reg;
    prevCond_next  = cond;
    // Edge history restarts on each entry to armed
    prevValid_next = (state_reg == atp_pkg::ATP_ARMED);
    conv_next      = 1'b0;
    trigd_next     = trigd_reg;
    // Reaching or passing the count ends it, so a count
    // lowered mid-run cannot leave the scan running on
    lastSample     = (samples_reg != 32'h00000000) &&
                     (doneCnt_reg + 32'h00000001 >= samples_reg);
    case (state_reg)
      atp_pkg::ATP_IDLE: begin
        if (cmdStart) begin
          // A new start forgets the last count and trigger
          doneCnt_next = 32'h00000000;
          trigd_next   = 1'b0;
          if (ctrl_reg[atp_pkg::CTRL_TRIG_EN]) begin
            state_next = atp_pkg::ATP_ARMED;
          end else begin
            state_next = atp_pkg::ATP_ACQ;
          end
        end
      end
      atp_pkg::ATP_ARMED: begin
        if (fire) begin
          // Sample count restarts with every trigger
          state_next   = atp_pkg::ATP_ACQ;
          doneCnt_next = 32'h00000000;
          trigd_next   = 1'b1;
        end
      end
      atp_pkg::ATP_ACQ: begin
        if (tick) begin
          conv_next    = 1'b1;
          doneCnt_next = doneCnt_reg + 32'h00000001;
          if (lastSample) begin
            if (ctrl_reg[atp_pkg::CTRL_RETRIG] &&
                ctrl_reg[atp_pkg::CTRL_TRIG_EN]) begin
              // Mode bits untouched, trigger armed again
              state_next = atp_pkg::ATP_ARMED;
            end else begin
              // Later crossings ignored until a new start
              state_next = atp_pkg::ATP_IDLE;
            end
          end
        end
      end
      default: state_next = atp_pkg::ATP_IDLE;
    endcase
    // Zero sample count runs until the host stops it;
    // stop wins over start and swallows this cycle's strobe
    if (cmdStop) begin
      state_next = atp_pkg::ATP_IDLE;
      conv_next  = 1'b0;
    end
    active_next = (state_next != atp_pkg::ATP_IDLE);
    acq_next    = (state_next == atp_pkg::ATP_ACQ);
  end

  // Pacing runs for the whole scan so a follower stays locked
  assign paceRun = active_reg;

  // Divider clamp and overrate detection sit in the pacer
  atp_pace_gen #(
    .MIN_CYC (MIN_CYC)
  ) u_pace (
    .clock     (clock),
    .resetn    (resetn),
    .run       (paceRun),
    .useExt    (ctrl_reg[atp_pkg::CTRL_EXT_PACE]),
    .divisor   (paceDiv_reg),
    .extPaceIn (extPaceIn),
    .tick      (tick),
    .paceOut   (paceClockOut),
    .overrate  (overPulse)
  );

  // Bus answer registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg    <= atp_pkg::CTRL_RESET;
      thrHigh_reg <= atp_pkg::THR_HIGH_RESET;
      thrLow_reg  <= atp_pkg::THR_LOW_RESET;
      paceDiv_reg <= atp_pkg::PACE_DIV_RESET;
      samples_reg <= atp_pkg::SAMPLES_RESET;
      over_reg    <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      thrHigh_reg <= thrHigh_next;
      thrLow_reg  <= thrLow_next;
      paceDiv_reg <= paceDiv_next;
      samples_reg <= samples_next;
      over_reg    <= over_next;
    end
  end

  // Scan state registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trigd_reg     <= 1'b0;
      state_reg     <= atp_pkg::ATP_IDLE;
      doneCnt_reg   <= 32'h00000000;
      prevCond_reg  <= 1'b0;
      prevValid_reg <= 1'b0;
      conv_reg      <= 1'b0;
      active_reg    <= 1'b0;
      acq_reg       <= 1'b0;
    end else begin
      trigd_reg     <= trigd_next;
      state_reg     <= state_next;
      doneCnt_reg   <= doneCnt_next;
      prevCond_reg  <= prevCond_next;
      prevValid_reg <= prevValid_next;
      conv_reg      <= conv_next;
      active_reg    <= active_next;
      acq_reg       <= acq_next;
    end
  end

  // Every output is a flip-flop, here or in the pacer
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign convStrobe = conv_reg;
  assign scanActive = active_reg;
  assign acquiring  = acq_reg;

endmodule : atp_trigger_pacing

// file: atp_pace_source.sv
// Purpose: Far-side pacing source, a second unit's pacing output
// Assumes: PERIOD kept at or above the design's least pacing period
// Notes:   Line held low outside a run, like a stopped pacing clock
`timescale 1ns/10ps
module atp_pace_source #(
  parameter int PERIOD = 8
) (
  input  wire logic clock,
  input  wire logic run,
  output logic      extPaceIn
);
  int   cnt  = 0;
  logic line = 1'b0;
  assign extPaceIn = line;
  // Period never under the ceiling rate
  always @(posedge clock) begin
    if (!run) begin
      cnt  <= 0;
      line <= 1'b0;
    end else begin
      cnt  <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      line <= (cnt < PERIOD / 2);
    end
  end
endmodule : atp_pace_source

// file: atp_trigger_pacing_checker.sv
// Purpose: Port-level checks for the trigger and pacing block
// Assumes: Zero-wait APB as handed over
// Notes:   Pacing output may lag the scan flag by a register
`timescale 1ns/10ps
module atp_trigger_pacing_checker #(
  parameter int MIN_CYC = 4
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        paceClockOut,
  input wire logic        convStrobe,
  input wire logic        scanActive,
  input wire logic        acquiring
);
  logic cmdWr;
  assign cmdWr = psel && penable && pready && pwrite
                 && paddr == atp_pkg::ADDR_CMD;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_START: assert property (
    cmdWr && pwdata[0] && !pwdata[1] && !scanActive |=> scanActive)
    else $error("start not taken");
  AST_STOP: assert property (
    cmdWr && pwdata[1] |=> !scanActive && !acquiring)
    else $error("stop not taken");
  AST_ACQ_IN_SCAN: assert property (acquiring |-> scanActive)
    else $error("acquiring outside scan");
  AST_STROBE_PULSE: assert property (convStrobe |=> !convStrobe)
    else $error("strobe wider than one cycle");
  AST_STROBE_CAUSE: assert property (convStrobe |-> $past(acquiring))
    else $error("strobe while not acquiring");
  AST_PACE_IDLE: assert property (!scanActive [*3] |-> !paceClockOut)
    else $error("pacing output without scan");
endmodule : atp_trigger_pacing_checker

bind atp_trigger_pacing atp_trigger_pacing_checker #(
  .MIN_CYC(MIN_CYC)
) chk_u (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .paceClockOut(paceClockOut),
  .convStrobe(convStrobe), .scanActive(scanActive),
  .acquiring(acquiring)
);

// file: test_acquisition_trigger_pacing.sv
// Purpose: Register, trigger mode and pacing tests over APB
// Assumes: MIN_CYC cut to 4 so pacing periods stay short
// Notes:   Outputs read at rising edges, before that edge's updates
`timescale 1ns/10ps
module test_acquisition_trigger_pacing;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, paceClockOut, convStrobe;
  logic        scanActive, acquiring, e, extPaceIn, extPrev;
  logic        extRun = 1'b0;
  logic [11:0] trig = 12'h800, pv;
  int          mismatches = 0, checked = 0, cycles = 0;
  int          strobes = 0, gap = 0, lastAt = 0;

  always #2 clock = ~clock;

  atp_trigger_pacing #(.MIN_CYC(4)) dut_u (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_input(trig),
    .extPaceIn(extPaceIn), .paceClockOut(paceClockOut),
    .convStrobe(convStrobe), .scanActive(scanActive),
    .acquiring(acquiring));

  atp_pace_source #(.PERIOD(8)) src_u (
    .clock(clock), .run(extRun), .extPaceIn(extPaceIn));

  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // Strobe spacing and count, plus the hang limit
  always @(posedge clock) begin
    cycles++;
    if (convStrobe === 1'b1) begin
      strobes++;
      gap    = cycles - lastAt;
      lastAt = cycles;
    end
    if (cycles == 5000) begin
      mismatches++;
      $display("CHECK FAILED %0t run too long", $time);
      end_sim;
    end
  end

  task automatic cmp32(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask : cmp32

  task automatic cmp1(input logic g, input logic x);
    cmp32({31'h0, g}, {31'h0, x});
  endtask : cmp1

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // Called just after a rising edge; holds all until pready seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    // A release still pending here gets its own idle edge first
    if (psel === 1'b1) @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cmp1(e, 1'b0);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp32(r, x);
    cmp1(e, 1'b0);
  endtask : chk

  initial begin
    cyc(8);
    resetn <= 1'b1;
    cyc(1);
    chk(atp_pkg::ADDR_CTRL, 32'h0);
    chk(atp_pkg::ADDR_THR_HIGH, 32'h800);
    chk(atp_pkg::ADDR_THR_LOW, 32'h800);
    chk(atp_pkg::ADDR_PACE_DIV, 32'h3e8);
    chk(atp_pkg::ADDR_SAMPLES, 32'h0);
    chk(atp_pkg::ADDR_CMD, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    cmp1(e, 1'b1);
    wr(atp_pkg::ADDR_THR_HIGH, 32'h1fff);
    chk(atp_pkg::ADDR_THR_HIGH, 32'hfff);
    wr(atp_pkg::ADDR_THR_HIGH, 32'ha00);
    wr(atp_pkg::ADDR_THR_LOW, 32'h600);
    wr(atp_pkg::ADDR_PACE_DIV, 32'h8);
    for (int m = 0; m < 4; m++) begin
      pv = m[0] ? 12'h400 : 12'hc00;
      gap = 0;
      wr(atp_pkg::ADDR_CTRL, 32'h1 | (m[0] ? 4 : 0) | (m[1] ? 8 : 0));
      trig <= pv;
      wr(atp_pkg::ADDR_CMD, 32'h1);
      cyc(6);
      cmp1(acquiring, !m[1]);
      if (m[1]) begin
        trig <= 12'h800;
        cyc(3);
        trig <= pv;
        cyc(4);
        cmp1(acquiring, 1'b1);
      end
      cyc(20);
      cmp32(32'(gap), 32'd8);
      wr(atp_pkg::ADDR_CMD, 32'h2);
      cyc(2);
      cmp1(scanActive, 1'b0);
    end
    // Short count so re-arming repeats within the run
    wr(atp_pkg::ADDR_SAMPLES, 32'h3);
    wr(atp_pkg::ADDR_CTRL, 32'h11);
    trig <= 12'hc00;
    strobes = 0;
    wr(atp_pkg::ADDR_CMD, 32'h1);
    cyc(100);
    cmp1(scanActive, 1'b1);
    cmp1(strobes > 6, 1'b1);
    wr(atp_pkg::ADDR_CMD, 32'h2);
    wr(atp_pkg::ADDR_CTRL, 32'h1);
    strobes = 0;
    wr(atp_pkg::ADDR_CMD, 32'h1);
    cyc(60);
    cmp1(scanActive, 1'b0);
    cmp32(32'(strobes), 32'd3);
    chk(atp_pkg::ADDR_STATUS, 32'h8);
    chk(atp_pkg::ADDR_DONE_CNT, 32'h3);
    trig <= 12'h800;
    cyc(3);
    trig <= 12'hc00;
    cyc(10);
    cmp1(scanActive, 1'b0);
    wr(atp_pkg::ADDR_SAMPLES, 32'h0);
    wr(atp_pkg::ADDR_CTRL, 32'h2);
    extRun <= 1'b1;
    wr(atp_pkg::ADDR_CMD, 32'h1);
    cyc(20);
    for (int i = 0; i < 16; i++) begin
      extPrev = extPaceIn;
      cyc(1);
      cmp1(paceClockOut, extPrev);
    end
    cmp32(32'(gap), 32'd8);
    chk(atp_pkg::ADDR_STATUS, 32'h2);
    wr(atp_pkg::ADDR_CMD, 32'h2);
    extRun <= 1'b0;
    cyc(4);
    cmp1(paceClockOut, 1'b0);
    end_sim;
  end
endmodule : test_acquisition_trigger_pacing
